// File: inc/usam_pkg.sv
`default_nettype none

package usam_pkg;

   // byte width of addresses, masks and frames
   localparam int USAM_DW = 8;
   localparam int USAM_AW = 8;

   // register offsets on the byte register port
   localparam logic [USAM_AW-1:0] ADDR_SLV_ADDR = 8'ha9;
   localparam logic [USAM_AW-1:0] ADDR_SMASK = 8'hb9;
   localparam logic [USAM_AW-1:0] ADDR_CTRL = 8'hc0;
   localparam logic [USAM_AW-1:0] ADDR_STAT = 8'hc1;
   localparam logic [USAM_AW-1:0] ADDR_DATA = 8'hc2;
   localparam logic [USAM_AW-1:0] ADDR_DROP = 8'hc3;

   // reset values and the saturation limit of the dropped-frame count
   localparam logic [USAM_DW-1:0] SLV_ADDR_RST = 8'h00;
   localparam logic [USAM_DW-1:0] SMASK_RST = 8'h00;
   localparam logic [USAM_DW-1:0] DROP_MAX = 8'hff;

   // control register fields
   localparam int CTRL_NINE_BIT = 0;
   localparam int CTRL_MP_EN = 1;

   // status register fields
   localparam int STAT_READY = 0;
   localparam int STAT_GIVEN = 1;
   localparam int STAT_BCAST = 2;
   localparam int STAT_BIT9 = 3;
   localparam int STAT_OVERRUN = 4;

   typedef struct packed {
      logic [USAM_DW-1:0] slv_addr;
      logic [USAM_DW-1:0] smask;
      logic nine_bit;
      logic mp_en;
      logic rx_ready;
      logic overrun;
      logic given;
      logic bcast;
      logic bit9;
      logic accept;
      logic [USAM_DW-1:0] rx_byte;
      logic [USAM_DW-1:0] drop_cnt;
      logic [USAM_DW-1:0] rdata;
   } usam_state_type;

   localparam usam_state_type USAM_STATE_RST = '{
      slv_addr: SLV_ADDR_RST,
      smask: SMASK_RST,
      nine_bit: 1'b0,
      mp_en: 1'b0,
      rx_ready: 1'b0,
      overrun: 1'b0,
      given: 1'b0,
      bcast: 1'b0,
      bit9: 1'b0,
      accept: 1'b0,
      rx_byte: 8'h00,
      drop_cnt: 8'h00,
      rdata: 8'h00
   };

   // true when value equals ref on every bit where care is one
   function automatic logic usam_care_match(
      input logic [USAM_DW-1:0] value,
      input logic [USAM_DW-1:0] ref_val,
      input logic [USAM_DW-1:0] care
   );
      usam_care_match = (((value ^ ref_val) & care) == 8'h00);
   endfunction : usam_care_match

endpackage : usam_pkg

`default_nettype wire

// File: inc/usam_match_if.sv
`timescale 1ns/1ps
`default_nettype none

interface usam_match_if;
   import usam_pkg::*;

   logic [USAM_DW-1:0] address_reg;
   logic [USAM_DW-1:0] mask_reg;
   logic [USAM_DW-1:0] rx_byte;
   logic given_hit;
   logic bcast_hit;

   modport ctrl (
      output address_reg,
      output mask_reg,
      output rx_byte,
      input given_hit,
      input bcast_hit
   );

   modport cmp (
      input address_reg,
      input mask_reg,
      input rx_byte,
      output given_hit,
      output bcast_hit
   );

endinterface : usam_match_if

`default_nettype wire

// File: hdl/usam_matcher.sv
`timescale 1ns/1ps
`default_nettype none

module usam_matcher (
   // comparison operands and results
   usam_match_if.cmp mif
);
   import usam_pkg::*;

   logic [USAM_DW-1:0] bcast_addr;

   // zero bits of the or act as don't-care, so the or is both value and care mask
   assign bcast_addr = mif.address_reg | mif.mask_reg;

   assign mif.given_hit = usam_care_match(mif.rx_byte, mif.address_reg, mif.mask_reg);

   assign mif.bcast_hit = usam_care_match(mif.rx_byte, bcast_addr, bcast_addr);

endmodule : usam_matcher

`default_nettype wire

// File: hdl/usam_addr_match.sv
// Operation
// - address frame matches given address where mask bits are one; mask zeros ignored
// - broadcast address is slave address OR mask; its zero bits are don't-care
// - reset clears slave address and mask registers to zero
// - with both registers at reset value every address frame matches
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module usam_addr_match (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // register port
   input wire logic [usam_pkg::USAM_AW-1:0] reg_addr,
   input wire logic [usam_pkg::USAM_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [usam_pkg::USAM_DW-1:0] reg_rdata,
   // received frames from the serial frame engine
   input wire logic frame_valid,
   input wire logic [usam_pkg::USAM_DW-1:0] frame_data,
   input wire logic frame_bit9,
   // report to software side
   output logic frame_accept,
   output logic [usam_pkg::USAM_DW-1:0] rx_data,
   output logic rx_ready,
   output logic given_match,
   output logic broadcast_match
);
   import usam_pkg::*;

   usam_state_type st_r;
   usam_state_type st_nxt;
   logic filtering;
   logic hit_any;
   logic accept_now;
   logic clear_ready;
   logic clear_overrun;

   usam_match_if match_if ();

   assign match_if.address_reg = st_r.slv_addr;
   assign match_if.mask_reg = st_r.smask;
   assign match_if.rx_byte = frame_data;

   usam_matcher u_matcher (
      .mif(match_if.cmp)
   );

   // address filtering only exists in nine-bit mode with multiprocessor reception on
   assign filtering = st_r.nine_bit & st_r.mp_en;

   assign hit_any = match_if.given_hit | match_if.bcast_hit;

   // data frames are dropped while filtering; software turns filtering off once selected
   assign accept_now = frame_valid & (~filtering | (frame_bit9 & hit_any));

   assign clear_ready = reg_wr & (reg_addr == ADDR_STAT) & reg_wdata[STAT_READY];
   assign clear_overrun = reg_wr & (reg_addr == ADDR_STAT) & reg_wdata[STAT_OVERRUN];

   always_comb begin
      st_nxt = st_r;
      st_nxt.accept = 1'b0;
      st_nxt.rdata = 8'h00;

      // register writes
      if (reg_wr) begin
         case (reg_addr)
            ADDR_SLV_ADDR: begin
               st_nxt.slv_addr = reg_wdata;
            end
            ADDR_SMASK: begin
               st_nxt.smask = reg_wdata;
            end
            ADDR_CTRL: begin
               st_nxt.nine_bit = reg_wdata[CTRL_NINE_BIT];
               st_nxt.mp_en = reg_wdata[CTRL_MP_EN];
            end
            ADDR_DROP: begin
               st_nxt.drop_cnt = 8'h00;
            end
            default: begin
            end
         endcase
      end

      // write-one-to-clear; a frame landing in the same cycle sets the flag again below
      if (clear_ready) begin
         st_nxt.rx_ready = 1'b0;
      end
      if (clear_overrun) begin
         st_nxt.overrun = 1'b0;
      end

      // register reads, data valid in the following cycle only
      if (reg_rd) begin
         case (reg_addr)
            ADDR_SLV_ADDR: begin
               st_nxt.rdata = st_r.slv_addr;
            end
            ADDR_SMASK: begin
               st_nxt.rdata = st_r.smask;
            end
            ADDR_CTRL: begin
               st_nxt.rdata[CTRL_NINE_BIT] = st_r.nine_bit;
               st_nxt.rdata[CTRL_MP_EN] = st_r.mp_en;
            end
            ADDR_STAT: begin
               st_nxt.rdata[STAT_READY] = st_r.rx_ready;
               st_nxt.rdata[STAT_GIVEN] = st_r.given;
               st_nxt.rdata[STAT_BCAST] = st_r.bcast;
               st_nxt.rdata[STAT_BIT9] = st_r.bit9;
               st_nxt.rdata[STAT_OVERRUN] = st_r.overrun;
            end
            ADDR_DATA: begin
               st_nxt.rdata = st_r.rx_byte;
            end
            ADDR_DROP: begin
               st_nxt.rdata = st_r.drop_cnt;
            end
            default: begin
               st_nxt.rdata = 8'h00;
            end
         endcase
      end

      // filtered-out frames are counted, saturating so software never sees a wrap
      if (frame_valid & ~accept_now) begin
         if (st_nxt.drop_cnt != DROP_MAX) begin
            st_nxt.drop_cnt = st_nxt.drop_cnt + 8'h01;
         end
      end

      // accepted frame: capture and report
      if (accept_now) begin
         st_nxt.accept = 1'b1;
         st_nxt.rx_byte = frame_data;
         st_nxt.bit9 = frame_bit9;
         st_nxt.given = filtering & match_if.given_hit;
         st_nxt.bcast = filtering & match_if.bcast_hit;
         if (st_nxt.rx_ready) begin
            st_nxt.overrun = 1'b1;
         end
         st_nxt.rx_ready = 1'b1;
      end
   end

   // both address registers return to zero so every address matches after reset
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= USAM_STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign frame_accept = st_r.accept;
   assign rx_data = st_r.rx_byte;
   assign rx_ready = st_r.rx_ready;
   assign given_match = st_r.given;
   assign broadcast_match = st_r.bcast;

   // checks

   default clocking chk_cb @(posedge core_clk);
   endclocking

   default disable iff (sys_rst);

   chk_given_hit: assert property (
      filtering && frame_valid && frame_bit9 &&
      usam_care_match(frame_data, st_r.slv_addr, st_r.smask)
      |=> frame_accept && given_match && (rx_data == $past(frame_data))
   ) else $error("given address frame not accepted");

   chk_bcast_hit: assert property (
      filtering && frame_valid && frame_bit9 &&
      ((frame_data & (st_r.slv_addr | st_r.smask)) == (st_r.slv_addr | st_r.smask))
      |=> frame_accept && broadcast_match
   ) else $error("broadcast address frame not accepted");

   chk_reset_clear: assert property (
      $past(sys_rst) && !sys_rst
      |-> (st_r.slv_addr == 8'h00) && (st_r.smask == 8'h00) && !frame_accept
   ) else $error("address registers not zero after reset");

   chk_reset_outputs: assert property (
      $past(sys_rst) && !sys_rst
      |-> !rx_ready && !given_match && !broadcast_match && (rx_data == 8'h00) && (reg_rdata == 8'h00)
   ) else $error("outputs not cleared after reset");

   chk_reset_accept: assert property (
      filtering && frame_valid && frame_bit9 &&
      (st_r.slv_addr == 8'h00) && (st_r.smask == 8'h00)
      |=> frame_accept && rx_ready && given_match && broadcast_match
   ) else $error("any address not accepted with cleared registers");

   chk_data_drop: assert property (
      filtering && frame_valid && !frame_bit9
      |=> !frame_accept
   ) else $error("data frame reported while filtering");

   chk_miss_drop: assert property (
      filtering && frame_valid && frame_bit9 &&
      !usam_care_match(frame_data, st_r.slv_addr, st_r.smask) &&
      ((frame_data & (st_r.slv_addr | st_r.smask)) != (st_r.slv_addr | st_r.smask))
      |=> !frame_accept && $stable(rx_data)
   ) else $error("unmatched address frame reported");

   chk_plain_pass: assert property (
      !filtering && frame_valid
      |=> frame_accept && !given_match && !broadcast_match
   ) else $error("frame lost with filtering off");

   chk_ready_hold: assert property (
      rx_ready && !clear_ready
      |=> rx_ready
   ) else $error("ready flag dropped without software clear");

   chk_read_late: assert property (
      reg_rd && (reg_addr == ADDR_SLV_ADDR) && !reg_wr
      |=> reg_rdata == $past(st_r.slv_addr)
   ) else $error("slave address read back wrong");

   chk_ready_set: assert property (
      accept_now
      |=> frame_accept && rx_ready && (rx_data == $past(frame_data))
   ) else $error("accepted frame not reported");

   // software may clear ready in the very cycle a frame lands; that frame must not be lost
   chk_set_wins: assert property (
      accept_now && clear_ready && clear_overrun
      |=> rx_ready && !st_r.overrun
   ) else $error("ready clear beat a frame in the same cycle");

   chk_overrun_set: assert property (
      accept_now && rx_ready && !clear_ready
      |=> st_r.overrun
   ) else $error("overrun not flagged");

   chk_no_spurious: assert property (
      !frame_valid
      |=> !frame_accept
   ) else $error("frame reported without a received frame");

   chk_drop_step: assert property (
      frame_valid && !accept_now && (st_r.drop_cnt != DROP_MAX) && !(reg_wr && (reg_addr == ADDR_DROP))
      |=> st_r.drop_cnt == $past(st_r.drop_cnt) + 8'h01
   ) else $error("dropped frame not counted");

   chk_drop_hold: assert property (
      (st_r.drop_cnt == DROP_MAX) && !(reg_wr && (reg_addr == ADDR_DROP))
      |=> st_r.drop_cnt == DROP_MAX
   ) else $error("dropped-frame count wrapped");

   chk_filter_on: assert property (
      reg_wr && (reg_addr == ADDR_CTRL)
      |=> filtering == ($past(reg_wdata[CTRL_NINE_BIT]) && $past(reg_wdata[CTRL_MP_EN]))
   ) else $error("filtering mode not taken from control write");

   chk_addr_write: assert property (
      reg_wr && (reg_addr == ADDR_SLV_ADDR)
      |=> st_r.slv_addr == $past(reg_wdata)
   ) else $error("slave address write lost");

   chk_mask_read: assert property (
      reg_rd && (reg_addr == ADDR_SMASK)
      |=> reg_rdata == $past(st_r.smask)
   ) else $error("slave address mask read back wrong");

   chk_rdata_idle: assert property (
      !reg_rd
      |=> reg_rdata == 8'h00
   ) else $error("read data left standing");

   cov_given_only: cover property (
      frame_accept && given_match && !broadcast_match
   );

   cov_bcast_only: cover property (
      frame_accept && broadcast_match && !given_match
   );

   cov_filtered: cover property (
      filtering && frame_valid && frame_bit9 && !accept_now
   );

   cov_set_clear: cover property (
      accept_now && clear_ready
   );

   cov_overrun: cover property (
      accept_now && rx_ready && !clear_ready
   );

endmodule : usam_addr_match

`default_nettype wire

// File: tb/usam_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module usam_master_model (
   // clock
   input wire logic core_clk,
   // frames toward the slave
   output logic frame_valid,
   output logic [usam_pkg::USAM_DW-1:0] frame_data,
   output logic frame_bit9
);
   import usam_pkg::*;

   initial begin
      frame_valid = 1'b0;
      frame_data = 8'h00;
      frame_bit9 = 1'b0;
   end

   // the caller picks the byte that agrees with the cared-for bits of the wanted slaves
   task automatic send(input logic [7:0] data, input logic bit9);
      @(posedge core_clk);
      frame_valid <= 1'b1;
      frame_data <= data;
      frame_bit9 <= bit9;
      @(posedge core_clk);
      // released lines show the inverse so a stale byte cannot match by luck
      frame_valid <= 1'b0;
      frame_data <= ~data;
      frame_bit9 <= ~bit9;
   endtask : send
endmodule : usam_master_model

`default_nettype wire

// File: tb/uart_slave_address_match_test.sv
`timescale 1ns/1ps
`default_nettype none

module uart_slave_address_match_test;
   import usam_pkg::*;

   typedef struct packed {
      logic [7:0] slv_addr;
      logic [7:0] smask;
      logic [7:0] data;
      logic bit9;
      logic acc;
      logic giv;
      logic bc;
   } usam_row_type;

   logic core_clk, sys_rst, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata;
   wire logic [7:0] reg_rdata, frame_data, rx_data;
   wire logic frame_valid, frame_bit9, frame_accept, rx_ready, given_match, broadcast_match;
   int n_mismatch = 0;
   int comparisons = 0;
   usam_row_type rows [10];

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   usam_addr_match u_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid),
      .frame_data(frame_data), .frame_bit9(frame_bit9), .frame_accept(frame_accept),
      .rx_data(rx_data), .rx_ready(rx_ready), .given_match(given_match),
      .broadcast_match(broadcast_match)
   );

   usam_master_model u_master (
      .core_clk(core_clk), .frame_valid(frame_valid), .frame_data(frame_data), .frame_bit9(frame_bit9)
   );

   task automatic wrap_up;
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic chk_bit(input string name, input logic exp, input logic got);
      chk(name, {7'h00, exp}, {7'h00, got});
   endtask : chk_bit

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(name, exp, reg_rdata);
   endtask : rd

   task automatic frame(input usam_row_type r);
      u_master.send(r.data, r.bit9);
      #1;
      chk_bit("frame_accept", r.acc, frame_accept);
      if (r.acc) begin
         chk("rx_data", r.data, rx_data);
         chk_bit("given_match", r.giv, given_match);
         chk_bit("broadcast_match", r.bc, broadcast_match);
         chk_bit("rx_ready", 1'b1, rx_ready);
      end
   endtask : frame

   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      rows = '{
         '{8'h00, 8'h00, 8'h5a, 1'b1, 1'b1, 1'b1, 1'b1},
         '{8'hf1, 8'hfa, 8'hf0, 1'b1, 1'b1, 1'b1, 1'b0},
         '{8'hf1, 8'hfa, 8'hf3, 1'b1, 1'b0, 1'b0, 1'b0},
         '{8'hf3, 8'hf9, 8'hf3, 1'b1, 1'b1, 1'b1, 1'b0},
         '{8'hf1, 8'hfa, 8'hff, 1'b1, 1'b1, 1'b0, 1'b1},
         '{8'hf2, 8'hfd, 8'hff, 1'b1, 1'b1, 1'b0, 1'b1},
         '{8'hf2, 8'hfd, 8'hfb, 1'b1, 1'b0, 1'b0, 1'b0},
         '{8'hf1, 8'hfa, 8'hfb, 1'b1, 1'b1, 1'b0, 1'b1},
         '{8'h56, 8'hfc, 8'hfe, 1'b1, 1'b1, 1'b0, 1'b1},
         '{8'h56, 8'hfc, 8'hf0, 1'b0, 1'b0, 1'b0, 1'b0}
      };
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd("slave_address", ADDR_SLV_ADDR, SLV_ADDR_RST);
      rd("slave_address_mask", ADDR_SMASK, SMASK_RST);
      // filtering off: a data frame passes and no match is claimed
      frame('{8'h00, 8'h00, 8'h33, 1'b0, 1'b1, 1'b0, 1'b0});
      chk_bit("given_match", 1'b0, given_match);
      wr(ADDR_STAT, 8'h01);
      wr(ADDR_CTRL, 8'h03);
      foreach (rows[i]) begin
         wr(ADDR_SLV_ADDR, rows[i].slv_addr);
         wr(ADDR_SMASK, rows[i].smask);
         frame(rows[i]);
         wr(ADDR_STAT, 8'h01);
      end
      rd("drop_count", ADDR_DROP, 8'h03);
      rd("slave_address_mask", ADDR_SMASK, 8'hfc);
      rd("unmapped", 8'h10, 8'h00);
      wr(ADDR_DATA, 8'h77);
      rd("last_byte", ADDR_DATA, 8'hfe);
      // all-ones broadcast, then a ready clear landing together with the next frame
      frame('{8'h56, 8'hfc, 8'hff, 1'b1, 1'b1, 1'b0, 1'b1});
      fork
         frame('{8'h56, 8'hfc, 8'hff, 1'b1, 1'b1, 1'b0, 1'b1});
         wr(ADDR_STAT, 8'h11);
      join
      rd("status_set_wins", ADDR_STAT, 8'h0d);
      frame('{8'h56, 8'hfc, 8'hff, 1'b1, 1'b1, 1'b0, 1'b1});
      rd("status_overrun", ADDR_STAT, 8'h1d);
      wr(ADDR_STAT, 8'h11);
      rd("status_cleared", ADDR_STAT, 8'h0c);
      // one control bit alone leaves filtering off
      wr(ADDR_CTRL, 8'h02);
      rd("control", ADDR_CTRL, 8'h02);
      frame('{8'h56, 8'hfc, 8'h12, 1'b0, 1'b1, 1'b0, 1'b0});
      wr(ADDR_CTRL, 8'h01);
      frame('{8'h56, 8'hfc, 8'h34, 1'b1, 1'b1, 1'b0, 1'b0});
      wr(ADDR_STAT, 8'h11);
      wr(ADDR_DROP, 8'h00);
      rd("drop_count_cleared", ADDR_DROP, 8'h00);
      wr(ADDR_CTRL, 8'h03);
      repeat (256) u_master.send(8'h00, 1'b0);
      rd("drop_count_saturated", ADDR_DROP, 8'hff);
      // a second reset in mid-run must bring the registers and outputs back to zero
      @(posedge core_clk);
      sys_rst <= 1'b1;
      @(posedge core_clk);
      sys_rst <= 1'b0;
      #1;
      chk("rx_data", 8'h00, rx_data);
      chk_bit("rx_ready", 1'b0, rx_ready);
      chk_bit("given_match", 1'b0, given_match);
      chk_bit("broadcast_match", 1'b0, broadcast_match);
      rd("slave_address", ADDR_SLV_ADDR, 8'h00);
      rd("slave_address_mask", ADDR_SMASK, 8'h00);
      // registers at their reset value: filtering takes any address as both kinds
      wr(ADDR_CTRL, 8'h03);
      frame('{8'h00, 8'h00, 8'ha5, 1'b1, 1'b1, 1'b1, 1'b1});
      wrap_up();
   end
endmodule : uart_slave_address_match_test

`default_nettype wire
